// ==== rtl/receive_chain_config_regs.sv ====
/*
 * receive chain configuration register bank with an avalon-mm slave.
 * holds the amplifier/filter word, the preamp/termination word and the
 * power profile, and drives registered decoded settings to the analog
 * chain. assumes a single 200 MHz clock and word addressing.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_params.svh"
module receive_chain_config_regs
    import rx_cfg_pkg::*;
(
    input wire logic clk_i,                 // system clock, 200 MHz
    input wire logic sys_rst_i,             // async reset, active high
    input wire logic [7:0] avs_address,     // word address
    input wire logic avs_read,              // read request
    input wire logic avs_write,             // write request
    input wire logic [3:0] avs_byteenable,  // byte lane enables
    input wire logic [31:0] avs_writedata,  // write data
    output logic [31:0] avs_readdata,       // read data, registered
    output logic avs_waitrequest,           // stall until answered
    output analog_ctrl_t ctrl_o,            // settings to the analog chain
    output logic cfg_update_o               // one-cycle pulse on applied change
);

    ////////////////////////////////////////////////////////////////
    // declarations
    bus_state_t state_reg;
    bus_state_t state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_accept;
    logic wr_amp;
    logic wr_pre;
    logic wr_pwr;
    logic [1:0] wr_be;
    logic [15:0] wr_data;
    logic [15:0] amp_word;
    logic [15:0] pre_word;
    logic [15:0] pwr_word;
    analog_ctrl_t ctrl_dec;
    analog_ctrl_t ctrl_reg;
    logic update_reg;
    logic [15:0] status_word;
    logic addr_hit;

    ////////////////////////////////////////////////////////////////
    // bus handshake: every request waits one cycle, then completes

    // waitrequest drops in the answer cycle only
    assign avs_waitrequest = (avs_read | avs_write) & (state_reg != BUS_ANSWER);

    // a write takes effect at the edge where waitrequest is low
    assign wr_accept = avs_write & (state_reg == BUS_ANSWER);

    // next state of the handshake
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                state_next = BUS_IDLE;
            end
            default: begin
                state_next = BUS_IDLE;
            end
        endcase
    end

    // handshake state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // write decode; upper bus lanes carry nothing and are dropped

    // only the low half-word holds data
    assign wr_be = avs_byteenable[1:0];
    assign wr_data = avs_writedata[15:0];

    // register selects; unmapped writes are ignored
    assign wr_amp = wr_accept && (avs_address == `IDX_AMP_FILTER);
    assign wr_pre = wr_accept && (avs_address == `IDX_PREAMP_TERM);
    assign wr_pwr = wr_accept && (avs_address == `IDX_POWER);

    ////////////////////////////////////////////////////////////////
    // storage; unnamed bits are masked, so host zeros are not relied on

    // amplifier gain, clamp, high-pass and anti-alias cutoff
    cfg_word_reg #(
        .WMASK(`MASK_AMP_FILTER)
    ) u_amp_reg (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_amp),
        .be_i(wr_be),
        .wd_i(wr_data),
        .q_o(amp_word)
    );

    // preamp gain, high-pass, input limit and termination
    cfg_word_reg #(
        .WMASK(`MASK_PREAMP_TERM)
    ) u_pre_reg (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_pre),
        .be_i(wr_be),
        .wd_i(wr_data),
        .q_o(pre_word)
    );

    // power profile holder; only the profile field is kept here
    cfg_word_reg #(
        .WMASK(`MASK_POWER)
    ) u_pwr_reg (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_pwr),
        .be_i(wr_be),
        .wd_i(wr_data),
        .q_o(pwr_word)
    );

    ////////////////////////////////////////////////////////////////
    // decode of stored words into analog settings

    // field meanings, clamp polarity and high-z substitution
    analog_decode u_decode (
        .amp_i(amp_word),
        .pre_i(pre_word),
        .pwr_i(pwr_word),
        .ctrl_o(ctrl_dec)
    );

    // settings are held in flip-flops until a later write changes them
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= '0;
            ctrl_reg.amp_gain_db <= `AMP_GAIN_LO_DB;
            ctrl_reg.amp_clamp_on <= 1'b1;  // low-noise profile, bit zero
            ctrl_reg.amp_hpf_on <= 1'b1;
            ctrl_reg.cutoff_mhz <= 6'd15;
            ctrl_reg.cutoff_valid <= 1'b1;
            ctrl_reg.pre_gain_db <= `PRE_GAIN_18_DB;
            ctrl_reg.pre_gain_valid <= 1'b1;
            ctrl_reg.pre_hpf_on <= 1'b1;
            ctrl_reg.term_ohms <= `TERM_50_OHM;
        end else begin
            ctrl_reg <= ctrl_dec;
        end
    end

    assign ctrl_o = ctrl_reg;

    // pulse when the applied settings change
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            update_reg <= 1'b0;
        end else begin
            update_reg <= (ctrl_dec != ctrl_reg);
        end
    end

    assign cfg_update_o = update_reg;

    ////////////////////////////////////////////////////////////////
    // status word: what the analog chain is really doing

    // flags for codes that have no documented meaning and live modes
    always_comb begin
        status_word = 16'h0000;
        status_word[0] = ~ctrl_reg.cutoff_valid;             // cutoff code unused
        status_word[1] = ~ctrl_reg.pre_gain_valid;           // preamp gain reserved
        status_word[2] = (ctrl_reg.power == PWR_RESERVED);   // profile reserved
        status_word[3] = ctrl_reg.term_highz;
        status_word[4] = ctrl_reg.amp_clamp_on;
        status_word[5] = ctrl_reg.chan_gain_en;
        status_word[6] = ctrl_reg.cust_term_on;
        status_word[7] = ctrl_reg.term_on & ~ctrl_reg.term_highz;
    end

    ////////////////////////////////////////////////////////////////
    // read path; data latched while waitrequest is high

    // read data mux, unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        addr_hit = 1'b1;
        case (avs_address)
            `IDX_AMP_FILTER: rdata_next[15:0] = amp_word;
            `IDX_PREAMP_TERM: rdata_next[15:0] = pre_word;
            `IDX_POWER: rdata_next[15:0] = pwr_word;
            `IDX_STATUS: rdata_next[15:0] = status_word;
            default: addr_hit = 1'b0;
        endcase
        if (!addr_hit) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // capture in the wait cycle so data stand at the completing edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && state_reg == BUS_IDLE) begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = rdata_reg;

endmodule
`default_nettype wire

// ==== rtl/rx_cfg_params.svh ====
/*
 * constants of the receive chain configuration register bank:
 * register indices, field positions, write masks, reset values.
 * assumes it is included by bare name from the modules.
 */
`ifndef RX_CFG_PARAMS_SVH
`define RX_CFG_PARAMS_SVH

// word indices; byte address is four times the index
`define IDX_AMP_FILTER 8'hC3
`define IDX_PREAMP_TERM 8'hC4
`define IDX_POWER 8'hC5
`define IDX_STATUS 8'hE0

// writable bit masks, unnamed bits stay zero
`define MASK_AMP_FILTER 16'h20DF
`define MASK_PREAMP_TERM 16'hF7FF
`define MASK_POWER 16'h0C00
`define CFG_RESET 16'h0000

// amp_filter_config fields
`define AMP_GAIN_BIT 13
`define AMP_CLAMP_CTL_BIT 7
`define AMP_CLAMP_LVL_BIT 6
`define AMP_HPF_OFF_BIT 4
`define AA_CUTOFF_LSB 0

// preamp_termination_config fields
`define CHAN_GAIN_EN_BIT 15
`define PRE_GAIN_LSB 13
`define PRE_HPF_OFF_BIT 12
`define LIMIT_LSB 9
`define TERM_EN_BIT 8
`define TERM_VAL_LSB 6
`define CUST_TERM_EN_BIT 5
`define CUST_TERM_LSB 0

// power register field
`define POWER_LSB 10

// gains in dB and termination in ohms
`define AMP_GAIN_LO_DB 6'd24
`define AMP_GAIN_HI_DB 6'd30
`define PRE_GAIN_18_DB 5'd18
`define PRE_GAIN_24_DB 5'd24
`define PRE_GAIN_12_DB 5'd12
`define TERM_50_OHM 9'd50
`define TERM_100_OHM 9'd100
`define TERM_200_OHM 9'd200
`define TERM_400_OHM 9'd400

// cutoff codes and frequencies in MHz
`define CUT_15_CODE 4'h0
`define CUT_20_CODE 4'h4
`define CUT_35_CODE 4'h5
`define CUT_30_CODE 4'h6
`define CUT_50_CODE 4'h7
`define CUT_10_CODE 4'h8

`endif

// ==== rtl/rx_cfg_pkg.sv ====
/*
 * types shared by the configuration register bank.
 * assumes rx_cfg_params.svh is on the include path.
 */
package rx_cfg_pkg;

    typedef enum logic [1:0] {
        PWR_LOW_NOISE = 2'b00,
        PWR_LOW_POWER = 2'b01,
        PWR_MEDIUM = 2'b10,
        PWR_RESERVED = 2'b11
    } power_profile_t;

    typedef enum logic [1:0] {
        LIMIT_AUTO = 2'b00,
        LIMIT_1V50 = 2'b01,
        LIMIT_1V15 = 2'b10,
        LIMIT_0V60 = 2'b11
    } input_limit_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    // decoded settings driven to the analog chain
    typedef struct packed {
        logic [5:0] amp_gain_db;
        logic amp_clamp_on;
        logic amp_clamp_0dbfs;
        logic amp_hpf_on;
        logic [5:0] cutoff_mhz;
        logic cutoff_valid;
        logic chan_gain_en;
        logic [4:0] pre_gain_db;
        logic pre_gain_valid;
        logic pre_hpf_on;
        input_limit_t input_limit;
        logic term_on;
        logic term_highz;
        logic [8:0] term_ohms;
        logic cust_term_on;
        logic [4:0] cust_term_code;
        power_profile_t power;
    } analog_ctrl_t;

endpackage

// ==== rtl/cfg_word_reg.sv ====
/*
 * one 16-bit configuration register with two byte lanes and a write mask.
 * assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_params.svh"
module cfg_word_reg #(
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input wire logic clk_i,       // system clock
    input wire logic sys_rst_i,   // async reset, active high
    input wire logic wr_i,        // write strobe
    input wire logic [1:0] be_i,  // byte lane enables
    input wire logic [15:0] wd_i, // write data
    output logic [15:0] q_o       // stored value
);
    ////////////////////////////////////////////////////////////////
    // one lane per byte, masked bits always read zero
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : lane
            logic [7:0] byte_reg;
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    byte_reg <= 8'h00;
                end else if (wr_i && be_i[g]) begin
                    byte_reg <= wd_i[8*g +: 8] & WMASK[8*g +: 8];
                end
            end
            assign q_o[8*g +: 8] = byte_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== rtl/analog_decode.sv ====
/*
 * decodes the stored register words into analog chain settings.
 * pure combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_params.svh"
module analog_decode
    import rx_cfg_pkg::*;
(
    input wire logic [15:0] amp_i,   // amp_filter_config word
    input wire logic [15:0] pre_i,   // preamp_termination_config word
    input wire logic [15:0] pwr_i,   // power register word
    output analog_ctrl_t ctrl_o      // decoded settings
);
    logic [1:0] gain_code;
    logic [3:0] cut_code;
    logic [1:0] term_code;

    ////////////////////////////////////////////////////////////////
    // field decode
    always_comb begin
        ctrl_o = '0;
        gain_code = pre_i[`PRE_GAIN_LSB +: 2];
        cut_code = amp_i[`AA_CUTOFF_LSB +: 4];
        term_code = pre_i[`TERM_VAL_LSB +: 2];
        ctrl_o.power = power_profile_t'(pwr_i[`POWER_LSB +: 2]);
        ctrl_o.amp_gain_db = amp_i[`AMP_GAIN_BIT] ? `AMP_GAIN_HI_DB
                                                  : `AMP_GAIN_LO_DB;
        // clamp bit is active low in low-noise profile only
        if (ctrl_o.power == PWR_LOW_NOISE) begin
            ctrl_o.amp_clamp_on = ~amp_i[`AMP_CLAMP_CTL_BIT];
        end else begin
            ctrl_o.amp_clamp_on = amp_i[`AMP_CLAMP_CTL_BIT];
        end
        ctrl_o.amp_clamp_0dbfs = amp_i[`AMP_CLAMP_LVL_BIT];
        ctrl_o.amp_hpf_on = ~amp_i[`AMP_HPF_OFF_BIT];
        ctrl_o.cutoff_valid = 1'b1;
        case (cut_code)
            `CUT_15_CODE: ctrl_o.cutoff_mhz = 6'd15;
            `CUT_20_CODE: ctrl_o.cutoff_mhz = 6'd20;
            `CUT_35_CODE: ctrl_o.cutoff_mhz = 6'd35;
            `CUT_30_CODE: ctrl_o.cutoff_mhz = 6'd30;
            `CUT_50_CODE: ctrl_o.cutoff_mhz = 6'd50;
            `CUT_10_CODE: ctrl_o.cutoff_mhz = 6'd10;
            default: ctrl_o.cutoff_valid = 1'b0;
        endcase
        ctrl_o.chan_gain_en = pre_i[`CHAN_GAIN_EN_BIT];
        ctrl_o.pre_gain_valid = 1'b1;
        case (gain_code)
            2'b00: ctrl_o.pre_gain_db = `PRE_GAIN_18_DB;
            2'b01: ctrl_o.pre_gain_db = `PRE_GAIN_24_DB;
            2'b10: ctrl_o.pre_gain_db = `PRE_GAIN_12_DB;
            default: ctrl_o.pre_gain_valid = 1'b0;
        endcase
        ctrl_o.pre_hpf_on = ~pre_i[`PRE_HPF_OFF_BIT];
        ctrl_o.input_limit = input_limit_t'(pre_i[`LIMIT_LSB +: 2]);
        ctrl_o.term_on = pre_i[`TERM_EN_BIT];
        case (term_code)
            2'b00: ctrl_o.term_ohms = `TERM_50_OHM;
            2'b01: ctrl_o.term_ohms = `TERM_100_OHM;
            2'b10: ctrl_o.term_ohms = `TERM_200_OHM;
            default: ctrl_o.term_ohms = `TERM_400_OHM;
        endcase
        // 50 ohms unsupported at 12 dB: code 00 means high impedance
        if (gain_code == 2'b10 && term_code == 2'b00) begin
            ctrl_o.term_highz = 1'b1;
            ctrl_o.term_ohms = 9'd0;
        end
        ctrl_o.cust_term_on = pre_i[`CUST_TERM_EN_BIT];
        ctrl_o.cust_term_code = ctrl_o.cust_term_on ?
                                pre_i[`CUST_TERM_LSB +: 5] : 5'h00;
    end
endmodule
`default_nettype wire

// ==== bench/rx_cfg_checker.sv ====
/* checker: bus timing and decoded settings of the register bank.
   assumes it is bound to the top module; one clock, async reset. */
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_params.svh"
module rx_cfg_checker
    import rx_cfg_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // async reset
    input wire logic [7:0] avs_address, // word address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // lane enables
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire analog_ctrl_t ctrl_o, // decoded settings
    input wire logic cfg_update_o // change pulse
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic wr_done;
    logic amp_wr;
    logic pre_wr;
    logic [15:0] wd_reg;
    // completed writes and the word they carried
    assign wr_done = avs_write && !avs_waitrequest;
    assign amp_wr = wr_done && avs_address == `IDX_AMP_FILTER;
    assign pre_wr = wr_done && avs_address == `IDX_PREAMP_TERM;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_reg <= 16'h0000;
        end else if (wr_done) begin
            wd_reg <= avs_writedata[15:0];
        end
    end
    a_one_wait: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait cycle count wrong");
    a_read_upper: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:16] == 16'h0000) else $error("read upper half not zero");
    a_amp_gain: assert property (amp_wr && avs_byteenable[1] |-> ##2
        ctrl_o.amp_gain_db == (wd_reg[13] ? `AMP_GAIN_HI_DB : `AMP_GAIN_LO_DB))
        else $error("amp gain decode wrong");
    a_amp_lowbyte: assert property (amp_wr && avs_byteenable[0] |-> ##2
        ctrl_o.amp_hpf_on == !wd_reg[4] && ctrl_o.amp_clamp_0dbfs == wd_reg[6] &&
        ctrl_o.amp_clamp_on == ((ctrl_o.power == PWR_LOW_NOISE) ? !wd_reg[7] : wd_reg[7]))
        else $error("amp clamp or highpass decode wrong");
    a_cutoff_code: assert property (amp_wr && avs_byteenable[0] |-> ##2
        ctrl_o.cutoff_valid == (wd_reg[3:0] == 4'h0 || (wd_reg[3:0] >= 4'h4 &&
        wd_reg[3:0] <= 4'h8))) else $error("cutoff validity wrong");
    a_pre_fields: assert property (pre_wr && avs_byteenable[1] |->
        ##2 ctrl_o.chan_gain_en == wd_reg[15] && ctrl_o.pre_hpf_on == !wd_reg[12] &&
        ctrl_o.input_limit == input_limit_t'(wd_reg[10:9]) && ctrl_o.term_on == wd_reg[8] &&
        ctrl_o.pre_gain_valid == (wd_reg[14:13] != 2'b11)) else $error("preamp decode wrong");
    a_highz_map: assert property (pre_wr && (&avs_byteenable[1:0]) |-> ##2
        ctrl_o.term_highz == (wd_reg[14:13] == 2'b10 && wd_reg[7:6] == 2'b00))
        else $error("high impedance decode wrong");
    a_cust_gate: assert property (ctrl_o.cust_term_code != 5'h00 |->
        ctrl_o.cust_term_on) else $error("custom code leaks while disabled");
    a_update_pulse: assert property (cfg_update_o |=> !cfg_update_o)
        else $error("update pulse too long");
    a_update_on_change: assert property (!$stable(ctrl_o) |-> cfg_update_o)
        else $error("update pulse missing after change");
endmodule
`default_nettype wire

// ==== bench/rx_cfg_host.sv ====
/* host model: avalon-mm master issuing register reads and writes.
   assumes the slave answers with waitrequest; waits are unbounded here. */
`timescale 1ns/1ps
`default_nettype none
module rx_cfg_host (
    input wire logic clk_i, // system clock
    output logic [7:0] avs_address, // word address
    output logic avs_read, // read request
    output logic avs_write, // write request
    output logic [3:0] avs_byteenable, // lane enables
    output logic [31:0] avs_writedata, // write data
    input wire logic avs_waitrequest, // stall
    input wire logic [31:0] avs_readdata // read data
);
    // idle bus from time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0000_0000;
    end
    // write held until waitrequest is sampled low
    task automatic bus_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= {16'h0000, d}; // upper half unused
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    // read held until waitrequest low; data taken at that edge
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_receive_chain_config_regs.sv ====
/* testbench for the receive chain configuration registers.
   assumes the host model and checker files compile before this one. */
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_params.svh"
module test_receive_chain_config_regs;
    import rx_cfg_pkg::*;
    logic clk_i;
    logic sys_rst_i;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    analog_ctrl_t ctrl_o;
    logic cfg_update_o;
    logic [31:0] rd;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [3:0] cut_code [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [5:0] cut_mhz [6] = '{6'd15, 6'd20, 6'd35, 6'd30, 6'd50, 6'd10};
    logic [4:0] gains [3] = '{5'd18, 5'd24, 5'd12};
    logic [8:0] ohms [4] = '{9'd50, 9'd100, 9'd200, 9'd400};
    receive_chain_config_regs receive_chain_config_regs_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctrl_o(ctrl_o),
        .cfg_update_o(cfg_update_o));
    rx_cfg_host rx_cfg_host_inst (.clk_i(clk_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_field(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // full write, then two edges until the decoded settings show it
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        rx_cfg_host_inst.bus_write(a, d, 4'hF);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rx_cfg_host_inst.bus_read(a, rd);
        check_reg(rd, exp);
    endtask
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rchk(`IDX_AMP_FILTER, 32'h0000_0000);
        rchk(`IDX_PREAMP_TERM, 32'h0000_0000);
        rchk(`IDX_STATUS, 32'h0000_0010);
        check_field(9'(ctrl_o.cutoff_mhz), 9'd15);
        check_field(9'(ctrl_o.pre_gain_db), 9'd18);
        wr(`IDX_AMP_FILTER, 16'hFFFF); // unnamed bits set on purpose
        rchk(`IDX_AMP_FILTER, 32'h0000_20DF);
        rchk(`IDX_STATUS, 32'h0000_0001);
        check_field(9'(ctrl_o.amp_gain_db), 9'd30);
        check_field(9'(ctrl_o.amp_clamp_on), 9'd0);
        check_field(9'(ctrl_o.amp_clamp_0dbfs), 9'd1);
        check_field(9'(ctrl_o.amp_hpf_on), 9'd0);
        check_field(9'(ctrl_o.cutoff_valid), 9'd0);
        rx_cfg_host_inst.bus_write(`IDX_AMP_FILTER, 16'h0000, 4'h1);
        rchk(`IDX_AMP_FILTER, 32'h0000_2000);
        for (int i = 0; i < 6; i++) begin
            wr(`IDX_AMP_FILTER, {12'h000, cut_code[i]});
            check_field(9'(ctrl_o.cutoff_mhz), 9'(cut_mhz[i]));
            check_field(9'(ctrl_o.cutoff_valid), 9'd1);
            check_field(9'(ctrl_o.amp_gain_db), 9'd24);
        end
        for (int p = 0; p < 4; p++) begin
            wr(`IDX_POWER, 16'(p) << 10);
            rchk(`IDX_POWER, 32'(p) << 10);
            check_field(9'(ctrl_o.power), 9'(p));
            for (int b = 0; b < 2; b++) begin
                wr(`IDX_AMP_FILTER, 16'(b) << 7);
                check_field(9'(ctrl_o.amp_clamp_on), 9'((p == 0) ? (b == 0) : (b == 1)));
            end
        end
        wr(`IDX_POWER, 16'h0000);
        for (int g = 0; g < 4; g++) begin
            wr(`IDX_PREAMP_TERM, (16'(g) << 13) | (16'(g % 2) << 15) | 16'h0100);
            rchk(`IDX_STATUS, (32'(g == 3) << 1) | (32'(g == 2) << 3) | (32'(g % 2) << 5)
                | (32'(g != 2) << 7));
            check_field(9'(ctrl_o.chan_gain_en), 9'(g % 2));
            check_field(9'(ctrl_o.pre_gain_valid), 9'(g != 3));
            check_field(9'(ctrl_o.term_highz), 9'(g == 2));
            if (g != 3) check_field(9'(ctrl_o.pre_gain_db), 9'(gains[g]));
            if (g != 3) check_field(ctrl_o.term_ohms, (g == 2) ? 9'd0 : 9'd50);
        end
        for (int t = 0; t < 4; t++) begin
            wr(`IDX_PREAMP_TERM, 16'h0100 | (16'(t) << 6) | (16'(t) << 9)
                | (16'(t % 2) << 12));
            check_field(ctrl_o.term_ohms, ohms[t]);
            check_field(9'(ctrl_o.input_limit), 9'(t));
            check_field(9'(ctrl_o.pre_hpf_on), 9'(t % 2 == 0));
            check_field(9'(ctrl_o.term_on), 9'd1);
        end
        wr(`IDX_PREAMP_TERM, 16'h0000);
        check_field(9'(ctrl_o.term_on), 9'd0);
        wr(`IDX_PREAMP_TERM, 16'h001F); // code before enable, must stay inert
        check_field(9'(ctrl_o.cust_term_on), 9'd0);
        check_field(9'(ctrl_o.cust_term_code), 9'd0);
        rchk(`IDX_PREAMP_TERM, 32'h0000_001F);
        wr(`IDX_PREAMP_TERM, 16'h003F); // enable set with the code
        check_field(9'(ctrl_o.cust_term_on), 9'd1);
        rchk(`IDX_STATUS, 32'h0000_0040);
        check_field(9'(ctrl_o.cust_term_code), 9'h01F);
        wr(`IDX_PREAMP_TERM, 16'hFFFF); // unnamed bit set on purpose
        rchk(`IDX_PREAMP_TERM, 32'h0000_F7FF);
        wr(8'h10, 16'hFFFF);
        rchk(8'h10, 32'h0000_0000);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rchk(`IDX_PREAMP_TERM, 32'h0000_0000);
        check_field(9'(ctrl_o.amp_gain_db), 9'd24);
        print_verdict();
    end
endmodule
bind receive_chain_config_regs rx_cfg_checker rx_cfg_checker_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctrl_o(ctrl_o),
    .cfg_update_o(cfg_update_o));
`default_nettype wire
